// ==== src/oscillator_clock_select.sv ====
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none

`include "osc_defines.svh"

// What this block does
// - Select bit one picks crystal, zero RC
// - Never enable crystal and RC together
// - Crystal mode: shared pin is amplifier output only
// - RC mode: port enable picks clock or I/O
// - Full-rate clock equals selected source clock
// - Half-rate clock is exactly half full-rate
// - Slow clock free-runs near 50 kHz
// - Wait mode leaves all clocks running
// - Stop disables source, full and half clocks
// - Stop gates watchdog slow clock if disabled
// - Break state keeps all clocks running
module oscillator_clock_select
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Option byte and integration unit controls.
    input wire logic [7:0] option_byte_value,
    input wire logic osc_enable_from_integration,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_state,
    // Oscillator outputs and shared pin inputs.
    input wire logic crystal_clock,
    input wire logic rc_clock,
    input wire logic osc_output_pin_in,
    input wire logic port_a_six_data,
    input wire logic port_a_six_dir,
    // Oscillator enables and clocks to the integration unit.
    output logic crystal_osc_enable,
    output logic rc_osc_enable,
    output logic full_rate_clock,
    output logic half_rate_clock,
    output logic internal_slow_clock,
    output logic watchdog_slow_clock,
    // Shared pin drive and keyboard input.
    output logic osc_output_pin_out,
    output logic osc_output_pin_oe,
    output logic keyboard_input_six
);

    // ************************************************************
    // Byte addresses of the registers.
    // ************************************************************
    localparam logic [17:0] OPTION_ADDR = {`OPTION_BYTE_IDX, 2'b00};
    localparam logic [17:0] PULLUP_ADDR = {`PORT_A_PULLUP_IDX, 2'b00};
    localparam logic [17:0] CONFIG_ADDR = {`CONFIG_TWO_IDX, 2'b00};
    localparam logic [17:0] STATUS_ADDR = {`OSC_STATUS_IDX, 2'b00};

    osc_pkg::osc_state_t state_ff;
    osc_pkg::osc_state_t nxt_state;

    logic crystal_oscillator_sync;
    logic rc_sync;
    logic pin_sync;
    logic slow_clock;
    logic sel_crystal_oscillator;
    logic src_sync;
    logic src_on;
    logic src_rise;
    logic port_mode;
    logic setup_phase;
    logic access_done;

    // ************************************************************
    // Pin synchronisers and the slow clock divider.
    // ************************************************************
    osc_sync2 u_sync_crystal_oscillator
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(crystal_clock),
        .sync_out(crystal_oscillator_sync)
    );

    osc_sync2 u_sync_rc
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(rc_clock),
        .sync_out(rc_sync)
    );

    osc_sync2 u_sync_pin
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(osc_output_pin_in),
        .sync_out(pin_sync)
    );

    // The divider has no mode inputs at all, so neither wait nor
    // break can interrupt it.
    osc_slow_clock u_slow
    (
        .pclk(pclk),
        .presetn(presetn),
        .slow_clock(slow_clock)
    );

    // ************************************************************
    // Address decode.
    // ************************************************************
    function automatic logic addr_mapped(input logic [17:0] a);
        addr_mapped = (a == OPTION_ADDR) || (a == PULLUP_ADDR) ||
                      (a == CONFIG_ADDR) || (a == STATUS_ADDR);
    endfunction : addr_mapped

    // Writes to the read-only words are refused like unmapped ones.
    function automatic logic bus_refused(
        input logic [17:0] a,
        input logic w
    );
        bus_refused = !addr_mapped(a) ||
            (w && (a == OPTION_ADDR || a == STATUS_ADDR));
    endfunction : bus_refused

    // Live state bits, so software can see which source is running.
    function automatic logic [7:0] status_byte(
        input osc_pkg::osc_state_t s
    );
        status_byte = 8'h00;
        status_byte[0] = s.crystal_oscillator_en;
        status_byte[1] = s.rc_en;
        status_byte[2] = s.full_rate;
        status_byte[3] = s.half_rate;
        status_byte[4] = s.slow_to_wdog;
        status_byte[5] = s.osc_pin.oe;
    endfunction : status_byte

    function automatic logic [31:0] read_word(
        input osc_pkg::osc_state_t s,
        input logic [17:0] a
    );
        read_word = 32'h0000_0000;
        if (a == OPTION_ADDR)
        begin
            read_word[7:0] = s.option_byte;
        end
        else if (a == PULLUP_ADDR)
        begin
            read_word[7:0] = s.pullup_reg;
        end
        else if (a == CONFIG_ADDR)
        begin
            read_word[7:0] = s.config_two;
        end
        else if (a == STATUS_ADDR)
        begin
            read_word[7:0] = status_byte(s);
        end
    endfunction : read_word

    // ************************************************************
    // Source selection.
    // ************************************************************
    // The select bit is taken straight from the flash cell, so the
    // erased value held by the read-back flop across reset can never
    // enable the wrong circuit just after release.
    assign sel_crystal_oscillator = option_byte_value[`OSC_TYPE_SELECT_BIT];

    // Stop or a low enable from the integration unit silence the
    // chosen source.
    assign src_on = osc_enable_from_integration && !stop_mode;

    // Edges are found on the gated source, so every full-rate rise,
    // including the first one after stop, brings one half-rate toggle.
    assign src_sync = sel_crystal_oscillator ? crystal_oscillator_sync : rc_sync;
    assign src_rise = src_on && src_sync && !state_ff.src_prev;

    assign port_mode = !sel_crystal_oscillator &&
        state_ff.pullup_reg[`SHARED_PIN_PORT_ENABLE_BIT];

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && state_ff.pready;

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb
    begin
        nxt_state = state_ff;

        // ********************************************************
        // Option byte.
        // ********************************************************
        // The flash cell is nonvolatile; its value is followed at all
        // times except in reset, which loads the erased value. Bits 6
        // to 0 are expected high but are shown as programmed.
        nxt_state.option_byte = option_byte_value;

        // ********************************************************
        // Oscillator enables.
        // ********************************************************
        // Only one oscillator circuit may be on, since both share
        // the input pin.
        nxt_state.crystal_oscillator_en = sel_crystal_oscillator && src_on;
        nxt_state.rc_en = !sel_crystal_oscillator && src_on;

        // ********************************************************
        // Output clocks.
        // ********************************************************
        // The full-rate clock follows the source with no division;
        // wait and break do not enter here.
        nxt_state.src_prev = src_on && src_sync;
        nxt_state.full_rate = src_on && src_sync;

        // Toggling on each source rise gives exactly half the
        // full-rate frequency; the partner divides it again.
        if (!src_on)
        begin
            nxt_state.half_rate = 1'b0;
        end
        else if (src_rise)
        begin
            nxt_state.half_rate = ~state_ff.half_rate;
        end

        // ********************************************************
        // Watchdog slow clock.
        // ********************************************************
        // The watchdog copy is gated only in stop with the disable
        // bit set.
        nxt_state.slow_to_wdog = slow_clock && !(stop_mode &&
            state_ff.config_two[`STOP_SLOW_CLOCK_DISABLE_BIT]);

        // ********************************************************
        // Shared output pin.
        // ********************************************************
        if (sel_crystal_oscillator)
        begin
            // Amplifier output only; port and keyboard are cut off.
            // The pin carries the inverted input clock.
            nxt_state.osc_pin.o = !crystal_oscillator_sync;
            nxt_state.osc_pin.oe = state_ff.crystal_oscillator_en;
            nxt_state.kbd_six = 1'b1;
        end
        else if (!port_mode)
        begin
            // RC clock is driven out while the enable bit is 0.
            nxt_state.osc_pin.o = rc_sync && src_on;
            nxt_state.osc_pin.oe = 1'b1;
            nxt_state.kbd_six = 1'b1;
        end
        else
        begin
            // General I/O and keyboard input.
            nxt_state.osc_pin.o = port_a_six_data;
            nxt_state.osc_pin.oe = port_a_six_dir;
            nxt_state.kbd_six = pin_sync;
        end

        // ********************************************************
        // Register bus.
        // ********************************************************
        // APB slave with zero wait states: the answer is prepared in
        // the setup cycle so every bus output comes from a flop.
        nxt_state.pready = setup_phase;
        if (setup_phase)
        begin
            nxt_state.pslverr = bus_refused(paddr, pwrite);
            nxt_state.prdata = pwrite ? 32'h0000_0000 :
                read_word(state_ff, paddr);
        end
        else if (access_done)
        begin
            nxt_state.pslverr = 1'b0;
            nxt_state.prdata = 32'h0000_0000;
        end

        if (access_done && pwrite && !state_ff.pslverr)
        begin
            if (paddr == PULLUP_ADDR)
            begin
                nxt_state.pullup_reg = pwdata[7:0];
            end
            else if (paddr == CONFIG_ADDR)
            begin
                nxt_state.config_two = pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= '0;
            state_ff.option_byte <= `OPTION_BYTE_ERASED;
            state_ff.pullup_reg <= `PORT_A_PULLUP_RESET;
            state_ff.config_two <= `CONFIG_TWO_RESET;
            state_ff.kbd_six <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops.
    // ************************************************************
    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign crystal_osc_enable = state_ff.crystal_oscillator_en;
    assign rc_osc_enable = state_ff.rc_en;
    assign full_rate_clock = state_ff.full_rate;
    assign half_rate_clock = state_ff.half_rate;
    assign internal_slow_clock = slow_clock;
    assign watchdog_slow_clock = state_ff.slow_to_wdog;
    assign osc_output_pin_out = state_ff.osc_pin.o;
    assign osc_output_pin_oe = state_ff.osc_pin.oe;
    assign keyboard_input_six = state_ff.kbd_six;

    // Mode inputs with no effect on the clocks; kept only so the
    // integration unit's interface is whole.
    logic unused_modes;
    assign unused_modes = wait_mode ^ break_state ^ pwdata[31];

endmodule : oscillator_clock_select

`default_nettype wire

// ==== shared/osc_defines.svh ====
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define OPTION_BYTE_IDX 16'hffd0
`define PORT_A_PULLUP_IDX 16'h000d
`define CONFIG_TWO_IDX 16'h001e
`define OSC_STATUS_IDX 16'h001f

// ****************************************************************
// Field positions.
// ****************************************************************
`define OSC_TYPE_SELECT_BIT 7
`define SHARED_PIN_PORT_ENABLE_BIT 6
`define STOP_SLOW_CLOCK_DISABLE_BIT 0

// ****************************************************************
// Reset and erased values.
// ****************************************************************
`define OPTION_BYTE_ERASED 8'hff
`define PORT_A_PULLUP_RESET 8'h00
`define CONFIG_TWO_RESET 8'h00

// ****************************************************************
// Timing of the internal slow clock.
// ****************************************************************
`define PCLK_HZ 20000000
`define SLOW_CLOCK_HZ 50000
`define SLOW_HALF_CYCLES (`PCLK_HZ / (2 * `SLOW_CLOCK_HZ))

`endif

// ==== shared/osc_pkg.sv ====
package osc_pkg;

    // One drive of a two-way pin.
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic level;
    } slow_state_t;

    typedef struct packed {
        logic [7:0] option_byte;
        logic [7:0] pullup_reg;
        logic [7:0] config_two;
        logic crystal_oscillator_en;
        logic rc_en;
        logic src_prev;
        logic full_rate;
        logic half_rate;
        logic slow_to_wdog;
        pin_drive_t osc_pin;
        pin_drive_t port_pin;
        logic kbd_six;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } osc_state_t;

endpackage : osc_pkg

// ==== src/osc_sync2.sv ====
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for one level from outside the pclk domain.
module osc_sync2
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);

    osc_pkg::sync_state_t state_ff;
    osc_pkg::sync_state_t nxt_state;

    always_comb
    begin
        nxt_state.s1 = async_in;
        nxt_state.s2 = state_ff.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.s2;

endmodule : osc_sync2

`default_nettype wire

// ==== src/osc_slow_clock.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "osc_defines.svh"

// Free-running slow clock made by dividing pclk; it has no enable
// because it must run from reset onward under all modes.
module osc_slow_clock
(
    input wire logic pclk,
    input wire logic presetn,
    output logic slow_clock
);

    localparam logic [7:0] HALF_LAST = 8'(`SLOW_HALF_CYCLES - 1);

    osc_pkg::slow_state_t state_ff;
    osc_pkg::slow_state_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        if (state_ff.count == HALF_LAST)
        begin
            nxt_state.count = 8'h00;
            nxt_state.level = ~state_ff.level;
        end
        else
        begin
            nxt_state.count = state_ff.count + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign slow_clock = state_ff.level;

endmodule : osc_slow_clock

`default_nettype wire

// ==== bench/osc_clock_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Port checker for the clock select block.
// ****************************************************************
module osc_clock_monitor
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [7:0] option_byte_value,
    input wire logic osc_enable_from_integration,
    input wire logic stop_mode,
    input wire logic crystal_clock,
    input wire logic crystal_osc_enable,
    input wire logic rc_osc_enable,
    input wire logic full_rate_clock,
    input wire logic half_rate_clock,
    input wire logic internal_slow_clock,
    input wire logic watchdog_slow_clock,
    input wire logic keyboard_input_six
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The slow clock period is too long for a repetition, so count it.
    logic last_ff;
    logic [8:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_ff <= 1'b0;
            cnt_ff <= 9'h000;
        end
        else
        begin
            last_ff <= internal_slow_clock;
            cnt_ff <= (internal_slow_clock != last_ff) ? 9'h000
                                                       : cnt_ff + 9'h001;
        end
    end

    sequence src_rise;
        $rose(crystal_clock) && crystal_osc_enable &&
        osc_enable_from_integration && !stop_mode ##1 !stop_mode[*3];
    endsequence
    sequence stop_held;
        stop_mode[*3];
    endsequence

    never_both_a: assert property (!(crystal_osc_enable && rc_osc_enable))
        else $error("Both oscillators enabled.");
    type_select_a: assert property ((crystal_osc_enable |->
        $past(option_byte_value[7], 1)) and (rc_osc_enable |->
        !$past(option_byte_value[7], 1))) else $error("Wrong oscillator.");
    full_follow_a: assert property (src_rise |-> ##[0:1] full_rate_clock)
        else $error("Full-rate clock missed a source edge.");
    stop_halt_a: assert property (stop_held |->
        !full_rate_clock && !half_rate_clock) else $error("Clock in stop.");
    half_step_a: assert property ($rose(full_rate_clock) |->
        half_rate_clock != $past(half_rate_clock))
        else $error("Half-rate clock missed a toggle.");
    slow_period_a: assert property (internal_slow_clock != last_ff |->
        cnt_ff inside {[9'h0c6:9'h0c8]}) else $error("Slow period off.");
    wdog_follow_a: assert property ($rose(internal_slow_clock) &&
        !stop_mode |-> ##[0:2] watchdog_slow_clock)
        else $error("Watchdog clock gated outside stop.");
    ready_next_a: assert property (psel && !penable |=> pready)
        else $error("No ready in the access cycle.");
    crystal_pin_a: assert property (crystal_osc_enable |->
        keyboard_input_six) else $error("Keyboard input live in crystal mode.");
endmodule : osc_clock_monitor

bind oscillator_clock_select osc_clock_monitor i_osc_clock_monitor
(
    .pclk, .presetn, .psel, .penable, .pready, .option_byte_value,
    .osc_enable_from_integration, .stop_mode, .crystal_clock,
    .crystal_osc_enable, .rc_osc_enable, .full_rate_clock,
    .half_rate_clock, .internal_slow_clock, .watchdog_slow_clock,
    .keyboard_input_six
);

`default_nettype wire

// ==== bench/siu_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Integration unit: mode bits are on, stop, wait, break.
// ****************************************************************
module siu_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] req,
    input wire logic half_rate_clock,
    output logic [3:0] mode,
    output logic bus_clock
);
    logic prev_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= 4'h0;
            prev_ff <= 1'b0;
            bus_clock <= 1'b0;
        end
        else
        begin
            mode <= req;
            prev_ff <= half_rate_clock;
            if (half_rate_clock && !prev_ff)
                bus_clock <= !bus_clock;
        end
    end
endmodule : siu_model

`default_nettype wire

// ==== bench/oscillator_clock_select_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module oscillator_clock_select_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] opt = 8'hff;
    logic [3:0] req = 4'h0;
    logic [5:0] div_ff = 6'h00;
    logic ext_pin = 1'b1;
    logic pdata = 1'b0;
    logic pdir = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, xen, ren, fr, hr, sc, wd, pout, poe, kbd;
    logic bus_clock, pin_in;
    logic [3:0] mode;
    logic [4:0] pv = 5'h00;
    logic [4:0] clk_now;
    int c[5] = '{0, 0, 0, 0, 0};
    int d[5];
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;

    always #25 pclk = ~pclk;
    assign pin_in = poe ? pout : ext_pin;
    assign clk_now = {wd, sc, bus_clock, hr, fr};

    oscillator_clock_select i_oscillator_clock_select
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .option_byte_value(opt),
        .osc_enable_from_integration(mode[0]), .stop_mode(mode[1]),
        .wait_mode(mode[2]), .break_state(mode[3]),
        .crystal_clock(div_ff[2]), .rc_clock(div_ff[3]),
        .osc_output_pin_in(pin_in), .port_a_six_data(pdata),
        .port_a_six_dir(pdir), .crystal_osc_enable(xen),
        .rc_osc_enable(ren), .full_rate_clock(fr), .half_rate_clock(hr),
        .internal_slow_clock(sc), .watchdog_slow_clock(wd),
        .osc_output_pin_out(pout), .osc_output_pin_oe(poe),
        .keyboard_input_six(kbd)
    );

    siu_model i_siu_model
    (
        .pclk(pclk), .presetn(presetn), .req(req),
        .half_rate_clock(hr), .mode(mode), .bus_clock(bus_clock)
    );

    // Counts rises of full, half, bus, slow and watchdog clocks.
    always @(posedge pclk)
    begin
        div_ff <= div_ff + 6'h01;
        pv <= clk_now;
        for (int i = 0; i < 5; i++)
            c[i] <= c[i] + int'(clk_now[i] && !pv[i]);
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            bad_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] wv);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wv;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic meas(input int n);
        int s[5];
        s = c;
        repeat (n) @(posedge pclk);
        foreach (d[i]) d[i] = c[i] - s[i];
    endtask : meas

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : do_reset

    task automatic t_regs();
        apb(1'b0, 18'h0007c, 32'h0);
        chk(rd & 32'h3, 32'h0);
        req <= 4'h1;
        apb(1'b0, 18'h3ff40, 32'h0);
        chk(rd, 32'hff);
        apb(1'b1, 18'h3ff40, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b0, 18'h00078, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 18'h00100, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b0, 18'h0007c, 32'h0);
        chk(rd & 32'h3, 32'h1);
    endtask : t_regs

    // Windows are whole periods, so phase never changes the counts.
    task automatic t_crystal();
        logic p0;
        req <= 4'hd;
        apb(1'b1, 18'h00034, 32'h40);
        meas(256);
        chk(32'(d[0]), 32'd32);
        chk(32'(d[1]), 32'd16);
        chk(32'(d[2]), 32'd8);
        chk({31'h0, poe}, 32'h1);
        chk({31'h0, kbd}, 32'h1);
        p0 = pout;
        repeat (4) @(posedge pclk);
        chk({31'h0, pout ^ p0}, 32'h1);
    endtask : t_crystal

    task automatic t_stop();
        req <= 4'h3;
        repeat (4) @(posedge pclk);
        meas(800);
        chk(32'(d[0] + d[1]), 32'h0);
        chk(32'(d[4]), 32'h2);
        apb(1'b1, 18'h00078, 32'h1);
        meas(800);
        chk(32'(d[3]), 32'h2);
        chk(32'(d[4]), 32'h0);
        req <= 4'h1;
        apb(1'b1, 18'h00078, 32'h0);
    endtask : t_stop

    task automatic t_rc();
        logic p0;
        opt <= 8'h7f;
        do_reset();
        apb(1'b0, 18'h0007c, 32'h0);
        chk(rd & 32'h3, 32'h2);
        chk({31'h0, poe}, 32'h1);
        meas(256);
        chk(32'(d[0]), 32'd16);
        chk(32'(d[1]), 32'd8);
        p0 = pout;
        repeat (8) @(posedge pclk);
        chk({31'h0, pout ^ p0}, 32'h1);
        apb(1'b1, 18'h00034, 32'h40);
        ext_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({30'h0, poe, kbd}, 32'h0);
        pdir <= 1'b1;
        pdata <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({30'h0, poe, pout}, 32'h3);
    endtask : t_rc

    initial
    begin
        do_reset();
        t_regs();
        t_crystal();
        t_stop();
        t_rc();
        conclude();
    end
endmodule : oscillator_clock_select_tb

`default_nettype wire
